//--- verilog/hbt_host.sv
/*
 Host end: reset sequencing and paced single-byte reads and writes.
 Assumes the controller shares clk_sys; wait is sampled through two flops.
*/
`timescale 1ns/1ps
module hbt_host #(
	parameter int RST_CYC = hbt_pkg::RST_MIN_CYC,
	parameter int STB_CYC = hbt_pkg::STAB_CYC
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic use_wait,
	input wire logic req,
	input wire logic req_write,
	input wire logic [15:0] req_addr,
	input wire logic [7:0] req_wdata,
	output logic ready,
	output logic done,
	output logic [7:0] rdata,
	output logic panel_power_en,
	hbt_if.host bus
);
	import hbt_pkg::*;
	typedef struct packed {
		hbt_state_e st;
		logic [31:0] cnt;
		logic [1:0] wt_s;
		logic wr;
		logic rd_n, wr_n, oe_n;
		logic [15:0] addr;
		logic [7:0] wd;
		logic [7:0] rd;
		logic done;
		logic pwr;
	} hbt_host_s;
	hbt_host_s q, next_q;
	always_comb begin
		next_q = q;
		next_q.done = 1'b0;
		next_q.wt_s = {q.wt_s[0], bus.wait_oe_n | bus.wait_n};
		next_q.cnt = q.cnt + 32'h1;
		case (q.st)
			HBT_RESET: begin
				if (q.cnt >= 32'(RST_CYC - 1)) begin // [RULE1]
					next_q.st = HBT_STAB;
					next_q.cnt = 32'h0;
				end
			end
			HBT_STAB: begin
				if (q.cnt >= 32'(STB_CYC - 1)) begin // [RULE4]
					next_q.st = HBT_IDLE;
					next_q.pwr = 1'b1; // [RULE5]
				end
			end
			HBT_IDLE: begin
				if (req) begin // [RULE6]
					next_q.st = HBT_SETUP;
					next_q.wr = req_write;
					next_q.addr = req_addr;
					next_q.wd = req_wdata;
					next_q.oe_n = !req_write;
					next_q.cnt = 32'h0;
				end
			end
			HBT_SETUP: begin
				next_q.st = HBT_STROBE;
				next_q.cnt = 32'h0;
				next_q.rd_n = q.wr;
				next_q.wr_n = !q.wr;
			end
			HBT_STROBE: begin
				// Sum of data setup and strobe width, then wait release
				if (q.cnt >= 32'(STROBE_MIN_CYC + SETUP_CYC) && // [RULE10]
					(!use_wait || q.wt_s[1])) begin // [RULE12] [RULE15]
					// A bus left undriven reads inverted, never as stale data
					if (!q.wr)
						next_q.rd = bus.data_d_oe_n ? ~bus.data_d2h :
							bus.data_d2h;
					next_q.rd_n = 1'b1;
					next_q.wr_n = 1'b1;
					next_q.st = HBT_GAP;
					next_q.cnt = 32'h0;
				end
			end
			HBT_GAP: begin
				// Write data held through the gap: the far end sees the
				// strobe rise through two flops and commits late
				if (q.cnt >= 32'(GAP_WR_CYC)) begin // [RULE11] [RULE13]
					next_q.st = HBT_IDLE;
					next_q.oe_n = 1'b1;
					next_q.done = 1'b1;
				end
			end
			default: next_q.st = HBT_IDLE;
		endcase
	end
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			q <= '0;
			q.st <= HBT_RESET;
			q.rd_n <= 1'b1;
			q.wr_n <= 1'b1;
			q.oe_n <= 1'b1;
			q.wt_s <= 2'h3;
		end else begin
			q <= next_q;
		end
	end
	assign ready = (q.st == HBT_IDLE);
	assign done = q.done;
	assign rdata = q.rd;
	assign panel_power_en = q.pwr;
	assign bus.rst_n = (q.st != HBT_RESET);
	assign bus.rd_n = q.rd_n;
	assign bus.wr_n = q.wr_n;
	assign bus.host_addr_bus = q.addr;
	assign bus.data_h2d = q.wd;
	assign bus.data_h_oe_n = q.oe_n;
endmodule : hbt_host

//--- include/hbt_pkg.sv
/*
 Constants and types shared by both ends of the parallel host port.
 Assumes one 100 MHz system clock (clk_sys) shared by both ends.
*/
// Function
// [RULE1] Host holds reset at least 1 ms
// [RULE2] Controller ignores accesses while in reset
// [RULE3] Panel outputs halt during reset
// [RULE4] Host waits 3 ms after reset release
// [RULE5] Panel supplies off one frame from reset
// [RULE6] Host initialises registers promptly after reset
// [RULE7] Wait driven low on strobe, released after
// [RULE8] Wait low at most 4 periods plus 2ns
// [RULE9] Read data valid 1 period after wait
// [RULE10] Write data set up 2 periods before strobe
// [RULE11] Strobe inactive gaps: read 1, ww 2, wr 5
// [RULE12] No-wait variant: strobe active 5 periods
// [RULE13] No-wait cycle: 6, 7, 10 periods
// [RULE14] No-wait read data valid within 4 periods
// [RULE15] Host holds strobe while wait low
package hbt_pkg;
	localparam int CLK_NS = 10;
	localparam int RST_MIN_NS = 1000000;
	localparam int STAB_NS = 3000000;
	localparam int RST_MIN_CYC = (RST_MIN_NS + CLK_NS - 1) / CLK_NS;
	localparam int STAB_CYC = (STAB_NS + CLK_NS - 1) / CLK_NS;
	// Strobe timing in system clock periods; the extra ns rounds up one
	localparam int WAIT_LOW_CYC = 3;
	localparam int STROBE_MIN_CYC = 5;
	localparam int GAP_RD_CYC = 1;
	localparam int GAP_WW_CYC = 3;
	localparam int GAP_WR_CYC = 6;
	localparam int SETUP_CYC = 3;
	localparam int FRAME_CYC = 64;
	localparam int LINE_CYC = 8;
	localparam int REG_COUNT = 16;
	localparam logic [7:0] DATA_RST = 8'h00;
	typedef enum logic [2:0] {HBT_IDLE, HBT_SETUP, HBT_STROBE, HBT_GAP,
		HBT_RESET, HBT_STAB} hbt_state_e;
endpackage : hbt_pkg

//--- include/hbt_if.sv
/*
 Parallel host port wires between host and controller.
 Assumes each end reads the other's data as inverted while it is released,
 and a released wait line as high.
*/
`timescale 1ns/1ps
interface hbt_if;
	logic rst_n;
	logic rd_n;
	logic wr_n;
	logic [15:0] host_addr_bus;
	logic [7:0] data_h2d;
	logic data_h_oe_n;
	logic [7:0] data_d2h;
	logic data_d_oe_n;
	logic wait_n;
	logic wait_oe_n;
	modport host (output rst_n, output rd_n, output wr_n,
		output host_addr_bus, output data_h2d, output data_h_oe_n,
		input data_d2h, input data_d_oe_n, input wait_n, input wait_oe_n);
	modport dev (input rst_n, input rd_n, input wr_n, input host_addr_bus,
		input data_h2d, input data_h_oe_n, output data_d2h,
		output data_d_oe_n, output wait_n, output wait_oe_n);
endinterface : hbt_if

//--- verilog/hbt_dev.sv
/*
 Controller end: small register file behind the strobes, panel outputs.
 Assumes strobes and reset arrive asynchronously and the host keeps timing.
*/
`timescale 1ns/1ps
module hbt_dev (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic use_wait,
	hbt_if.dev bus,
	output logic [3:0] panel_pixel_data,
	output logic panel_line_pulse,
	output logic panel_frame_toggle
);
	import hbt_pkg::*;
	typedef struct packed {
		logic [1:0] rd_s, wr_s, rs_s;
		logic wr_d;
		logic active;
		logic [2:0] wcnt;
		logic wait_lo;
		logic [7:0] dout;
		logic dout_en;
		logic [REG_COUNT-1:0][7:0] regs;
		logic [7:0] pcnt;
		logic [3:0] pix;
		logic line;
		logic frame;
	} hbt_dev_s;
	hbt_dev_s q, next_q;
	logic in_rst;
	always_comb begin
		next_q = q;
		next_q.rd_s = {q.rd_s[0], bus.rd_n};
		next_q.wr_s = {q.wr_s[0], bus.wr_n};
		next_q.rs_s = {q.rs_s[0], bus.rst_n};
		next_q.wr_d = q.wr_s[1];
		in_rst = !q.rs_s[1];
		if (in_rst) begin
			next_q.active = 1'b0; // [RULE2]
			next_q.wait_lo = 1'b0;
			next_q.dout_en = 1'b0;
			next_q.wcnt = 3'h0;
		end else if (!q.active && (!q.rd_s[1] || !q.wr_s[1])) begin
			next_q.active = 1'b1;
			next_q.wait_lo = use_wait; // [RULE7]
			next_q.wcnt = 3'h0;
			if (!q.rd_s[1]) begin
				next_q.dout_en = 1'b1;
				next_q.dout = q.regs[bus.host_addr_bus[3:0]]; // [RULE14]
			end
		end else if (q.active) begin
			if (q.wait_lo) begin
				next_q.wcnt = q.wcnt + 3'h1;
				if (q.wcnt == 3'(WAIT_LOW_CYC - 1))
					next_q.wait_lo = 1'b0; // [RULE8] [RULE9]
			end
			if (q.rd_s[1] && q.wr_s[1]) begin
				next_q.active = 1'b0;
				next_q.wait_lo = 1'b0;
				next_q.dout_en = 1'b0;
				// A released bus reads inverted, so a late commit shows up
				if (!q.wr_d)
					next_q.regs[bus.host_addr_bus[3:0]] =
						bus.data_h_oe_n ? ~bus.data_h2d : bus.data_h2d;
			end
		end
		if (in_rst) begin
			next_q.pcnt = 8'h00; // [RULE3]
		end else begin
			next_q.pcnt = q.pcnt + 8'h01;
			next_q.line = (q.pcnt[2:0] == 3'(LINE_CYC - 1));
			if (q.pcnt == 8'(FRAME_CYC - 1)) begin
				next_q.frame = !q.frame;
				next_q.pcnt = 8'h00;
			end
			next_q.pix = q.regs[q.pcnt[3:0]][3:0];
		end
	end
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			q <= '0;
			q.rd_s <= 2'h3;
			q.wr_s <= 2'h3;
			q.wr_d <= 1'b1;
		end else begin
			q <= next_q;
		end
	end
	assign bus.wait_n = !q.wait_lo;
	// Released whenever no access is active, so the line floats high
	assign bus.wait_oe_n = !(use_wait && q.active); // [RULE7]
	assign bus.data_d2h = q.dout;
	assign bus.data_d_oe_n = !q.dout_en;
	assign panel_pixel_data = q.pix;
	assign panel_line_pulse = q.line;
	assign panel_frame_toggle = q.frame;
endmodule : hbt_dev

//--- tb/hbt_properties.sv
/* Checker on the host port wires.
 Sees only interface signals; one clock, reset active high. */
`timescale 1ns/1ps
module hbt_properties (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic rst_n,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic [7:0] data_h2d,
	input wire logic data_h_oe_n,
	input wire logic data_d_oe_n,
	input wire logic wait_n,
	input wire logic wait_oe_n
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	a_wait_bounded: assert property (
		!wait_n && !wait_oe_n |-> ##[1:4] (wait_n || wait_oe_n))
		else $error("wait low too long");
	a_wait_release: assert property (
		$rose(rd_n && wr_n) |-> ##[0:4] (wait_oe_n && data_d_oe_n))
		else $error("wait or data not released");
	a_read_data: assert property (
		$rose(wait_n) && !wait_oe_n && !rd_n |-> ##[0:1] !data_d_oe_n)
		else $error("read data late after wait");
	a_strobe_width: assert property (
		$fell(rd_n && wr_n) |-> (!rd_n || !wr_n)[*5])
		else $error("strobe too short");
	a_strobe_gap: assert property (
		$rose(rd_n && wr_n) |-> (rd_n && wr_n)[*6])
		else $error("strobe gap too short");
	a_write_setup: assert property (
		$rose(wr_n) |-> !$past(data_h_oe_n, 3)
		&& $past(data_h2d, 3) == $past(data_h2d))
		else $error("write data setup short");
	a_wait_hold: assert property (
		!wait_n && !wait_oe_n |=> !(rd_n && wr_n))
		else $error("strobe ended during wait");
	a_reset_quiet: assert property (
		!rst_n |-> rd_n && wr_n && data_d_oe_n && wait_oe_n)
		else $error("bus active in reset");
endmodule : hbt_properties

//--- tb/host_bus_cycle_timing_test.sv
/* Bench: host and controller ends joined, register model checked.
 Assumes one 100 MHz clock and inputs driven at the falling edge. */
`timescale 1ns/1ps
module host_bus_cycle_timing_test;
	import hbt_pkg::*;
	// Reset outlasts one panel frame so panel power stays off that long
	localparam int RST_T = 64;
	localparam int STB_T = 20;
	logic clk_sys = 0, rst = 0, use_wait = 0, req = 0, req_write = 0;
	logic ready, done, panel_power_en, panel_line_pulse, panel_frame_toggle;
	logic [15:0] req_addr = 16'h0000;
	logic [7:0] req_wdata = 8'h00, rdata;
	logic [3:0] panel_pixel_data;
	logic [7:0] mem [16];
	logic [31:0] r;
	logic [5:0] pan;
	int err_total = 0, n_compared = 0, seed = 32'h56E0;
	hbt_if bus ();
	hbt_host #(.RST_CYC(RST_T), .STB_CYC(STB_T)) i_hbt_host (
		.clk_sys(clk_sys), .rst(rst), .use_wait(use_wait), .req(req),
		.req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
		.ready(ready), .done(done), .rdata(rdata),
		.panel_power_en(panel_power_en), .bus(bus));
	hbt_dev i_hbt_dev (.clk_sys(clk_sys), .rst(rst), .use_wait(use_wait),
		.bus(bus), .panel_pixel_data(panel_pixel_data),
		.panel_line_pulse(panel_line_pulse),
		.panel_frame_toggle(panel_frame_toggle));
	hbt_properties i_hbt_properties (.clk_sys, .rst, .rst_n(bus.rst_n),
		.rd_n(bus.rd_n), .wr_n(bus.wr_n), .data_h2d(bus.data_h2d),
		.data_h_oe_n(bus.data_h_oe_n), .data_d_oe_n(bus.data_d_oe_n),
		.wait_n(bus.wait_n), .wait_oe_n(bus.wait_oe_n));
	always #5 clk_sys = ~clk_sys;
	task chk(input logic bad);
		n_compared++;
		if (bad !== 1'b0) begin
			$display("Error %0t: mismatch", $time);
			err_total++;
		end
	endtask : chk
	task do_reset(input logic w);
		int k;
		// Raised after an edge so the asynchronous reset sees a real rise
		@(negedge clk_sys);
		rst = 1;
		use_wait = w;
		repeat (5) @(negedge clk_sys);
		rst = 0;
		foreach (mem[i]) mem[i] = DATA_RST;
		// Request while the port is held in reset; it must be dropped
		req = 1;
		repeat (3) @(negedge clk_sys);
		req = 0;
		pan = {panel_pixel_data, panel_line_pulse, panel_frame_toggle};
		repeat (10) @(negedge clk_sys);
		chk(pan !== {panel_pixel_data, panel_line_pulse,
			panel_frame_toggle});
		chk(bus.rst_n !== 1'b0 || panel_power_en !== 1'b0);
		k = 13;
		while (ready !== 1'b1 && k < 300) begin
			@(negedge clk_sys);
			k++;
		end
		chk(k < RST_T + STB_T || k >= 300);
		chk(panel_power_en !== 1'b1);
	endtask : do_reset
	task access(input logic w, input logic [15:0] a, input logic [7:0] d);
		int k;
		k = 0;
		while (ready !== 1'b1 && k < 300) begin
			@(negedge clk_sys);
			k++;
		end
		req = 1;
		req_write = w;
		req_addr = a;
		req_wdata = d;
		@(negedge clk_sys);
		req = 0;
		while (done !== 1'b1 && k < 300) begin
			@(negedge clk_sys);
			k++;
		end
		chk(k >= 300 || (!w && rdata !== mem[a[3:0]]));
		if (w) mem[a[3:0]] = d;
	endtask : access
	task final_report();
		$display("Compared %0d, errors %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : final_report
	initial begin
		#50000;
		err_total++;
		final_report();
	end
	initial begin
		for (int v = 0; v < 2; v++) begin
			do_reset(v[0]);
			access(1'b0, 16'h0000, 8'h00);
			repeat (24) begin
				r = $random(seed);
				access(r[31], r[15:0], r[23:16]);
			end
		end
		final_report();
	end
endmodule : host_bus_cycle_timing_test
